// *** core/wss_clk_pick.sv ***
/*
 Generator clock tick selection. Both oscillator tick strobes are
 assumed synchronous to clk_i; the chosen one times the dead band.
*/
module wss_clk_pick
    import wss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sel_i,
    input wire logic sys_tick_i,
    input wire logic fast_tick_i,
    output logic tick_o
);
    wire chosen = sel_i ? fast_tick_i : sys_tick_i; // R1

    // Registered so the tick is glitch free when the select changes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= chosen;
    end

    // The first edge after reset sees a tick sampled during reset, so skip it
    AST_CLK_SEL: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        !$past(rst_i) |-> tick_o == $past(sel_i ? fast_tick_i : sys_tick_i))
        else $error("generator tick does not follow clock select");
endmodule : wss_clk_pick

// *** core/wss_ctrl.sv ***
/*
 Waveform steering and shutdown controller: registers on classic
 Wishbone, source and clock selection, steering with override, and
 auto-shutdown with restart. Sources, shutdown inputs and ticks are
 synchronous to clk_i. Dead-band counters proper are outside; here
 only the interval before the inactive level is timed.
*/
// Our own choices: register access over Wishbone and the register offsets.
// Overview of operation
// R1: Clock select 0 system, 1 fast oscillator
// R2: Four-bit code picks data source; 1110-1111 reserved
// R3: Steer enable 1: output carries polarized data
// R4: Steer enable 0: output takes override bit
// R5: Steering reg: overrides 7-4, enables 3-0
// R6: Steering applies only in modes 00x
// R7: Mode 001 double-buffers steer enables
// R8: Shutdown status shows active shutdown state
// R9: Restart enable allows automatic shutdown recovery
// R10: B/D shutdown level from two-bit code
// R11: A/C shutdown level from two-bit code
// R12: Code 00 inactive level after dead band
// R13: Software may set shutdown before enabling
// R14: Resume only at next data rising edge
// R15: Unimplemented register bits read zero
// R16: Interrupt flag set on every shutdown event
// R17: Software clear ignored while condition present
// R18: Auto-restart clears status when conditions gone
// R19: Mode 001 synchronous, 000 asynchronous steering
// R20: Shutdown levels hit all outputs together
module wss_ctrl
    import wss_pkg::*;
#(
    parameter int NSRC = WSS_NSRC,
    parameter int NSHD = 5
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    output logic err_o,
    input wire logic [NSRC-1:0] src_i,
    input wire logic [NSHD-1:0] shd_src_i,
    input wire logic sys_tick_i,
    input wire logic fast_tick_i,
    output logic [3:0] out_o,
    output logic [3:0] out_oe_o,
    output logic irq_flag_o
);
    import wss_pkg::*;

    logic clk_sel;
    logic [3:0] src_sel;
    logic [7:0] steer;
    logic [3:0] steer_live;
    logic shd_stat;
    logic ren;
    logic [1:0] bd_shutdown_level;
    logic [1:0] ac_shutdown_level;
    logic en;
    logic [3:0] pol;
    logic [2:0] mode;
    logic [NSHD-1:0] shd_en;
    logic [5:0] dbd;
    logic [5:0] dbd_cnt;
    logic data;
    logic data_rise;
    logic tick;
    wss_state_t state;
    wss_state_t next_state;

    wss_clk_pick u_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(clk_sel),
        .sys_tick_i(sys_tick_i),
        .fast_tick_i(fast_tick_i),
        .tick_o(tick)
    );

    wss_src_mux #(.NSRC(NSRC)) u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(src_sel),
        .src_i(src_i),
        .data_o(data),
        .rise_o(data_rise)
    );

    // Bus decode; any access word-selected, byte lane 0 carries data, except the shutdown enables, which come from lane 1
    wire req = cyc_i & stb_i & ~ack_o & ~err_o;
    wire hit_clk = adr_i == WSS_ADDR_CLK;
    wire hit_dat = adr_i == WSS_ADDR_DAT;
    wire hit_str = adr_i == WSS_ADDR_STR;
    wire hit_shd = adr_i == WSS_ADDR_SHD;
    wire hit_ctl = adr_i == WSS_ADDR_CTL;
    wire hit_dbd = adr_i == WSS_ADDR_DBD;
    wire hit_sts = adr_i == WSS_ADDR_STS;
    wire mapped = hit_clk | hit_dat | hit_str | hit_shd | hit_ctl | hit_dbd | hit_sts;
    wire wr0 = req & we_i & sel_i[0];
    wire [7:0] wd = dat_i[7:0];

    // Shutdown condition from enabled sources
    wire shd_cond = |(shd_src_i & shd_en);
    wire sw_set = wr0 & hit_shd & wd[WSS_SHD_BIT];
    wire sw_clr = wr0 & hit_shd & ~wd[WSS_SHD_BIT] & ~shd_cond; // R17
    wire auto_clr = ren & ~shd_cond; // R18 R9
    wire shd_event = (shd_cond | sw_set) & ~shd_stat;
    wire steer_mode = mode[2:1] == 2'b00; // R6 R19
    wire sync_mode = mode == WSS_MODE_SYNC; // R7 R19

    // Read mux; unimplemented bits are zero-filled
    wire [7:0] rd_shd = {shd_stat, ren, bd_shutdown_level, ac_shutdown_level, 2'b00}; // R15
    wire [7:0] rd_ctl = {en, pol, mode};
    wire [7:0] rd_sts = {data, 2'b00, shd_cond, 1'b0, 1'b0, state};
    wire [7:0] rd =
        hit_clk ? {7'h00, clk_sel} : // R15
        hit_dat ? {4'h0, src_sel} : // R15
        hit_str ? steer :
        hit_shd ? rd_shd :
        hit_ctl ? rd_ctl :
        hit_dbd ? {2'b00, dbd} :
        hit_sts ? rd_sts : 8'h00;

    // Bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= req & mapped;
            err_o <= req & ~mapped;
            dat_o <= {24'h00_0000, rd};
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_sel <= 1'b0;
            src_sel <= 4'h0;
            steer <= WSS_ZERO8;
            ren <= WSS_SHD_RST[WSS_REN_BIT];
            bd_shutdown_level <= WSS_SHD_RST[WSS_BD_SHUTDOWN_LEVEL_LO +: 2];
            ac_shutdown_level <= WSS_SHD_RST[WSS_AC_SHUTDOWN_LEVEL_LO +: 2];
            en <= 1'b0;
            pol <= 4'h0;
            mode <= WSS_MODE_ASYNC;
            shd_en <= '0;
            dbd <= WSS_DBD_RST;
        end
        else
        begin
            if (wr0 & hit_clk)
                clk_sel <= wd[0]; // R1
            if (wr0 & hit_dat)
                src_sel <= wd[3:0]; // R2
            if (wr0 & hit_str)
                steer <= wd; // R5
            if (wr0 & hit_shd)
            begin
                ren <= wd[WSS_REN_BIT];
                bd_shutdown_level <= wd[WSS_BD_SHUTDOWN_LEVEL_LO +: 2];
                ac_shutdown_level <= wd[WSS_AC_SHUTDOWN_LEVEL_LO +: 2];
            end
            if (wr0 & hit_ctl)
            begin
                en <= wd[WSS_EN_BIT];
                pol <= wd[WSS_POL_LO +: 4];
                mode <= wd[WSS_MODE_LO +: 3];
            end
            if (wr0 & hit_dbd)
            begin
                dbd <= wd[5:0];
                shd_en <= dat_i[8 +: NSHD];
            end
        end
    end

    // Shutdown status: setting wins over any clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shd_stat <= WSS_SHD_RST[WSS_SHD_BIT];
        else if (shd_cond | sw_set)
            shd_stat <= 1'b1; // R8 R13
        else if (sw_clr | auto_clr)
            shd_stat <= 1'b0; // R8 R17 R18
    end

    // Interrupt flag, sticky, cleared by writing 1 to status bit 7
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_flag_o <= 1'b0;
        else if (shd_event)
            irq_flag_o <= 1'b1; // R16
        else if (wr0 & hit_sts & wd[7])
            irq_flag_o <= 1'b0;
    end

    // Live enables: immediate in async mode, at data rising edge in sync
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            steer_live <= 4'h0;
        else if (!sync_mode || data_rise)
            steer_live <= steer[3:0]; // R7
    end

    // Output state: run, dead-band wait, hold, wait for data edge
    always_comb
    begin
        next_state = state;
        case (state)
            WSS_RUN:
                if (shd_stat | shd_cond)
                    next_state = WSS_DEAD;
            WSS_DEAD:
                if (dbd_cnt == 6'h00)
                    next_state = WSS_HOLD; // R12
            WSS_HOLD:
                if (!shd_stat)
                    next_state = WSS_WAIT_EDGE;
            WSS_WAIT_EDGE:
                if (shd_stat)
                    next_state = WSS_HOLD;
                else if (data_rise)
                    next_state = WSS_RUN; // R14
            default:
                next_state = WSS_HOLD;
        endcase
    end

    // State and dead-band count, counted in generator clock ticks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= WSS_DEAD;
            dbd_cnt <= 6'h00;
        end
        else
        begin
            state <= next_state;
            if (state != WSS_DEAD)
                dbd_cnt <= dbd;
            else if (tick && dbd_cnt != 6'h00)
                dbd_cnt <= dbd_cnt - 6'h01; // R12
        end
    end

    // Per-output value: steering or override, then shutdown level
    logic [3:0] next_out;
    logic [3:0] next_oe;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_out
            wire [1:0] lvl = (g == 1 || g == 3) ? bd_shutdown_level : ac_shutdown_level; // R10 R11
            wire polar = data ^ pol[g];
            wire steered = steer_live[g] ? polar : steer[4 + g]; // R3 R4
            wire run_val = steer_mode ? steered : polar; // R6
            wire in_shd = state != WSS_RUN; // R20
            wire inact = (state == WSS_DEAD) ? run_val : pol[g]; // R12
            assign next_out[g] = !in_shd ? run_val :
                lvl == WSS_LVL_HIGH ? 1'b1 :
                lvl == WSS_LVL_LOW ? 1'b0 :
                lvl == WSS_LVL_INACT ? inact : 1'b0;
            // Shutdown levels drive even while disabled, so pins can be parked first
            assign next_oe[g] = in_shd ? (lvl != WSS_LVL_TRI) : en; // R13 R10 R11
        end
    endgenerate

    // Registered pins so the power stage sees no decode glitches
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_o <= 4'h0;
            out_oe_o <= 4'h0;
        end
        else
        begin
            out_o <= next_out;
            out_oe_o <= next_oe;
        end
    end

    AST_SW_CLR_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        shd_cond |=> shd_stat)
        else $error("status cleared while shutdown condition present");
    AST_AUTO_RESTART: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        shd_stat && ren && !shd_cond && !sw_set |=> !shd_stat)
        else $error("auto-restart did not clear status");
    AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        shd_event |=> irq_flag_o)
        else $error("shutdown event did not set interrupt flag");
    AST_RESUME_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        state == WSS_WAIT_EDGE && !data_rise |=> state != WSS_RUN)
        else $error("outputs resumed without data rising edge");
    AST_HIGH_LVL: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        state == WSS_HOLD && ac_shutdown_level == WSS_LVL_HIGH |=> out_o[0] && out_o[2])
        else $error("A/C not driven high in shutdown");
    AST_BD_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        state == WSS_HOLD && bd_shutdown_level == WSS_LVL_LOW |=> !out_o[1] && !out_o[3])
        else $error("B/D not driven low in shutdown");
    AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        state == WSS_RUN && steer_mode && !steer_live[0] |=> out_o[0] == $past(steer[4]))
        else $error("output A does not follow override");
    AST_STEER: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        state == WSS_RUN && steer_mode && steer_live[2] |=> out_o[2] == $past(data ^ pol[2]))
        else $error("output C does not carry polarized data");
    AST_SYNC_BUF: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        sync_mode && !data_rise |=> steer_live == $past(steer_live))
        else $error("sync enables changed without data edge");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    COV_SHUTDOWN: cover property (@(posedge clk_i) disable iff (rst_i) shd_event);
    COV_RESUME: cover property (@(posedge clk_i) disable iff (rst_i)
        state == WSS_WAIT_EDGE ##1 state == WSS_RUN);
    COV_TRI: cover property (@(posedge clk_i) disable iff (rst_i) out_oe_o != 4'hf && en);
    COV_SYNC_LOAD: cover property (@(posedge clk_i) disable iff (rst_i) sync_mode && data_rise);
endmodule : wss_ctrl

// *** core/wss_src_mux.sv ***
/*
 Data input source multiplexer with a registered rising edge detect.
 Sources are synchronous to clk_i; reserved codes give a low input.
*/
module wss_src_mux
    import wss_pkg::*;
#(
    parameter int NSRC = WSS_NSRC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] sel_i,
    input wire logic [NSRC-1:0] src_i,
    output logic data_o,
    output logic rise_o
);
    wire valid_sel = sel_i < WSS_SRC_COUNT; // R2
    wire picked = valid_sel ? src_i[sel_i] : 1'b0; // R2

    // Data register and edge detect share one flop stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_o <= 1'b0;
            rise_o <= 1'b0;
        end
        else
        begin
            data_o <= picked;
            rise_o <= picked & ~data_o;
        end
    end

    AST_SRC_RSVD: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        $past(sel_i) >= WSS_SRC_COUNT |-> !data_o)
        else $error("reserved input code passed data");
endmodule : wss_src_mux

// *** shared/wss_pkg.sv ***
/*
 Package for the waveform steering and shutdown controller: register
 offsets, field positions, reset values, codes and timing.
 Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package wss_pkg;
    // Register byte offsets
    localparam logic [7:0] WSS_ADDR_CLK = 8'h00;
    localparam logic [7:0] WSS_ADDR_DAT = 8'h04;
    localparam logic [7:0] WSS_ADDR_STR = 8'h08;
    localparam logic [7:0] WSS_ADDR_SHD = 8'h0c;
    localparam logic [7:0] WSS_ADDR_CTL = 8'h10;
    localparam logic [7:0] WSS_ADDR_DBD = 8'h14;
    localparam logic [7:0] WSS_ADDR_STS = 8'h18;
    // Shutdown control field positions
    localparam int WSS_SHD_BIT = 7;
    localparam int WSS_REN_BIT = 6;
    localparam int WSS_BD_SHUTDOWN_LEVEL_LO = 4;
    localparam int WSS_AC_SHUTDOWN_LEVEL_LO = 2;
    // Control register field positions
    localparam int WSS_EN_BIT = 7;
    localparam int WSS_POL_LO = 3;
    localparam int WSS_MODE_LO = 0;
    // Reset values
    localparam logic [7:0] WSS_SHD_RST = 8'h14;
    localparam logic [7:0] WSS_ZERO8 = 8'h00;
    // Shutdown level codes
    localparam logic [1:0] WSS_LVL_INACT = 2'h0;
    localparam logic [1:0] WSS_LVL_TRI = 2'h1;
    localparam logic [1:0] WSS_LVL_LOW = 2'h2;
    localparam logic [1:0] WSS_LVL_HIGH = 2'h3;
    // Output modes
    localparam logic [2:0] WSS_MODE_ASYNC = 3'h0;
    localparam logic [2:0] WSS_MODE_SYNC = 3'h1;
    // Input select codes at or above this are reserved
    localparam logic [3:0] WSS_SRC_COUNT = 4'he;
    localparam int WSS_NSRC = 14;
    // Default dead-band interval in generator clocks
    localparam logic [5:0] WSS_DBD_RST = 6'h04;
    // Output state machine
    typedef enum logic [1:0] {WSS_RUN, WSS_DEAD, WSS_HOLD, WSS_WAIT_EDGE} wss_state_t;
endpackage : wss_pkg

// *** verification/wss_ctrl_tb_top.sv ***
/*
 Self-checking bench for the steering and shutdown controller.
 Assumes classic Wishbone with a one-cycle ack and sources synchronous to clk_i.
*/
module wss_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wss_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack;
    logic err;
    logic [13:0] src = 14'h0;
    logic [4:0] shd = 5'h0;
    logic sys_tick = 1'b0;
    logic fast_tick = 1'b1;
    logic [3:0] outs;
    logic [3:0] oe;
    logic irq;
    logic [3:0] gate;
    logic [31:0] q;
    logic e;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    wss_ctrl wss_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
        .err_o(err), .src_i(src), .shd_src_i(shd), .sys_tick_i(sys_tick),
        .fast_tick_i(fast_tick), .out_o(outs), .out_oe_o(oe), .irq_flag_o(irq));
    wss_power_stage wss_power_stage_i (.drive_i(outs), .drive_oe_i(oe), .gate_o(gate));

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    // Slow generator tick; also cuts a hung run short
    always @(posedge clk_i)
    begin
        sys_tick <= ~sys_tick;
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // One classic cycle; holds the request until ack or err is sampled
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        // A missing answer counts as a mismatch
        if (ack !== 1'b1 && err !== 1'b1)
            fails++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    // Reads until the value shows, a bounded number of times, then compares
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        do
        begin
            xfer(a, 1'b0, 32'h0);
            n++;
        end
        while (q !== exp && n < 10);
        chk(q, exp);
    endtask : rd

    // Waits a bounded time for the flag and pin levels, then compares
    task automatic wait_out(input logic [4:0] exp);
        int n;
        for (n = 0; n < 40 && {irq, gate} !== exp; n++)
            @(negedge clk_i);
        chk({27'h0, irq, gate}, {27'h0, exp});
        // Return on a rising edge so the next stimulus lands there
        @(posedge clk_i);
    endtask : wait_out

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(WSS_ADDR_SHD, {24'h0, WSS_SHD_RST});
        chk({28'h0, oe}, 32'h0);
        rd(WSS_ADDR_STR, 32'h0);
        wr(WSS_ADDR_CLK, 32'hff);
        rd(WSS_ADDR_CLK, 32'h01);
        wr(WSS_ADDR_DAT, 32'hff);
        rd(WSS_ADDR_DAT, 32'h0f);
        xfer(8'h1c, 1'b0, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Forced levels while still disabled: A/C high, B/D low
        wr(WSS_ADDR_SHD, 32'haf);
        wait_out(5'h15);
        chk({28'h0, oe}, 32'hf);
        wr(WSS_ADDR_STS, 32'h80);
        wr(WSS_ADDR_DAT, 32'h0);
        wr(WSS_ADDR_CTL, 32'h80);
        wr(WSS_ADDR_STR, 32'ha1);
        wr(WSS_ADDR_SHD, 32'h2c);
        repeat (4) @(posedge clk_i);
        wait_out(5'h05);
        src <= 14'h1;
        wait_out(5'h0b);
        // Every source code, reserved ones giving a low input
        for (int c = 0; c < 16; c++)
        begin
            wr(WSS_ADDR_DAT, 32'(c));
            src <= (c < 14) ? 14'(1 << c) : 14'h3fff;
            wait_out((c < 14) ? 5'h0b : 5'h0a);
            src <= 14'h0;
            wait_out(5'h0a);
        end
        // Hardware shutdown from source 0 without restart
        wr(WSS_ADDR_DAT, 32'h0);
        wr(WSS_ADDR_DBD, 32'h0104);
        shd <= 5'h1;
        wait_out(5'h15);
        rd(WSS_ADDR_SHD, 32'hac);
        wr(WSS_ADDR_SHD, 32'h2c);
        rd(WSS_ADDR_SHD, 32'hac);
        shd <= 5'h0;
        repeat (4) @(posedge clk_i);
        rd(WSS_ADDR_SHD, 32'hac);
        // Auto-restart clears status once the condition is gone
        wr(WSS_ADDR_STS, 32'h80);
        wr(WSS_ADDR_SHD, 32'hec);
        shd <= 5'h1;
        wait_out(5'h15);
        shd <= 5'h0;
        rd(WSS_ADDR_SHD, 32'h6c);
        wait_out(5'h15);
        src <= 14'h1;
        wait_out(5'h1b);
        // Synchronous steering: new enables wait for a data rising edge
        wr(WSS_ADDR_CTL, 32'h81);
        wr(WSS_ADDR_STR, 32'ha5);
        repeat (4) @(posedge clk_i);
        wait_out(5'h1b);
        src <= 14'h0;
        wait_out(5'h1a);
        src <= 14'h1;
        wait_out(5'h1f);
        // Polarity on A, then the inactive level after the dead band
        wr(WSS_ADDR_CTL, 32'h89);
        rd(WSS_ADDR_CTL, 32'h89);
        wait_out(5'h1e);
        rd(WSS_ADDR_DBD, 32'h04);
        wr(WSS_ADDR_STS, 32'h80);
        wr(WSS_ADDR_SHD, 32'h40);
        shd <= 5'h1;
        wait_out(5'h11);
        shd <= 5'h0;
        repeat (4) @(posedge clk_i);
        wait_out(5'h11);
        src <= 14'h0;
        repeat (2) @(posedge clk_i);
        src <= 14'h1;
        wait_out(5'h1e);
        // Outside the steering modes the override bits are ignored
        wr(WSS_ADDR_CTL, 32'h82);
        src <= 14'h0;
        wait_out(5'h10);
        complete_run();
    end
endmodule : wss_ctrl_tb_top

// *** verification/wss_power_stage.sv ***
/*
 Power stage model facing the four waveform outputs.
 Assumes each gate input has a pull-down, so a released output reads low.
*/
module wss_power_stage
(
    input wire logic [3:0] drive_i,
    input wire logic [3:0] drive_oe_i,
    output logic [3:0] gate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released gates fall to the pull-down level, never to a stale value
    assign gate_o = drive_i & drive_oe_i;
endmodule : wss_power_stage
